//--- verilog/dsc_pkg.sv
// Purpose: Shared constants and types for the disconnector control block
// Assumes: 50 MHz system clock, APB register access, 1 ms time base
// Notes: All times are in milliseconds unless the name says cycles
package dsc_pkg;
    // Clock rate and the 1 ms tick derived from it
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    localparam int TICK_CYC = CLK_HZ / MS_PER_S;

    // Register byte offsets
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_PULSE = 8'h04;
    localparam logic [7:0] ADDR_MAXOP = 8'h08;
    localparam logic [7:0] ADDR_MAXINT = 8'h0C;
    localparam logic [7:0] ADDR_SBO = 8'h10;
    localparam logic [7:0] ADDR_CMD = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;
    localparam logic [7:0] ADDR_OPCNT = 8'h1C;

    // Timer settings: reset values and legal ranges
    localparam logic [15:0] PULSE_DEF_MS = 16'h03E8;
    localparam logic [15:0] PULSE_MIN_MS = 16'h0064;
    localparam logic [15:0] MAXOP_DEF_MS = 16'h2710;
    localparam logic [15:0] MAXOP_MIN_MS = 16'h000A;
    localparam logic [15:0] MAXINT_DEF_MS = 16'h2710;
    localparam logic [15:0] MAXINT_MIN_MS = 16'h0014;
    localparam logic [15:0] SBO_DEF_MS = 16'h1388;
    localparam logic [15:0] SBO_MIN_MS = 16'h03E8;
    localparam logic [15:0] SBO_MAX_MS = 16'h4E20;
    localparam logic [15:0] SETTING_MAX_MS = 16'hEA60;
    localparam logic [15:0] EARLY_END_MIN_MS = 16'h03E8;
    localparam logic [15:0] OPER_PULSE_MS = 16'h0096;

    // Control models
    typedef enum logic [1:0] {
        MODEL_DIRECT_NORMAL = 2'h0,
        MODEL_DIRECT_ENH = 2'h1,
        MODEL_SBO_ENH = 2'h2
    } dsc_model_t;

    // Switch type attribute
    typedef enum logic [2:0] {
        SW_NA = 3'h0,
        SW_LOAD_BREAK = 3'h1,
        SW_DISCONNECTOR = 3'h2,
        SW_EARTHING = 3'h3,
        SW_HS_EARTHING = 3'h4
    } dsc_swtype_t;

    // Position status codes
    localparam logic [1:0] POS_INTERMEDIATE = 2'h0;
    localparam logic [1:0] POS_OPEN = 2'h1;
    localparam logic [1:0] POS_CLOSED = 2'h2;
    localparam logic [1:0] POS_BAD = 2'h3;

    // Configuration word, bits [5:0] of the CFG register
    typedef struct packed {
        logic forcedCheck;
        dsc_swtype_t swType;
        dsc_model_t model;
    } dsc_cfg_t;

    localparam dsc_cfg_t CFG_RST = '{forcedCheck: 1'b1, swType: SW_DISCONNECTOR,
                                     model: MODEL_DIRECT_NORMAL};

    // Command word, bits [3:0] of the CMD register
    typedef struct packed {
        logic skipCheck;
        logic select;
        logic remote;
        logic close;
    } dsc_cmd_t;

    // Synchronised pin group
    typedef struct packed {
        logic localOk;
        logic remoteOk;
        logic openOk;
        logic closeOk;
        logic blocked;
        logic posClosed;
        logic posOpen;
    } dsc_pins_t;

    // Command sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SELECTED = 3'b010,
        ST_PULSE = 3'b100
    } dsc_state_t;
endpackage

//--- verilog/dsc_switch_ctrl.sv
// Purpose: Disconnector command, supervision and position status logic
// Assumes: APB master on sys_clk; permit and position pins are asynchronous
// Notes: Local and remote commands both arrive through the CMD register

// Notes on behaviour
// - Commands checked before driving switchgear; status forwarded
// - Source permit and direction permit both needed
// - Local commands need local permit active
// - Remote commands need remote permit active
// - Open needs open permit
// - Close needs close permit
// - Process block refuses any operation
// - Three control models, direct normal default
// - Forced check ignores skip request, default on
// - Enhanced models flag missing position change
// - Pulse length setting 100..60000 ms
// - Early withdraw on success, not before 1000 ms
// - Intermediate or bad hidden until timer expires
// - SBO select expires without command
// - Switch type setting, default disconnector, readable
// - Position code: 0 mid, 1 open, 2 closed, 3 bad
// - 150 ms operation pulse on change to open or closed position
// - Operation counter, clearable by software
// - Status event on reported status change
module dsc_switch_ctrl
    import dsc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic local_control_permit,
    input wire logic remote_control_permit,
    input wire logic open_permit,
    input wire logic close_permit,
    input wire logic process_block,
    input wire logic open_position_in,
    input wire logic closed_position_in,
    output logic open_pulse_out,
    output logic close_pulse_out,
    output logic [1:0] position_status_code,
    output logic operation_pulse,
    output logic status_event,
    output logic invalid_position_error
);
    // Saturating millisecond step, advanced only on the tick
    function automatic logic [15:0] msStep(input logic [15:0] c, input logic t);
        return (t && c != 16'hFFFF) ? c + 16'h0001 : c;
    endfunction

    // Clamp a written setting into its legal range
    function automatic logic [15:0] clampMs(input logic [15:0] v, input logic [15:0] lo,
                                             input logic [15:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Pin synchroniser: first stage feeds only the second
    dsc_pins_t pinMeta_r, pins_r;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pinMeta_r <= '0;
            pins_r <= '0;
        end else begin
            pinMeta_r <= '{local_control_permit, remote_control_permit, open_permit,
                           close_permit, process_block, closed_position_in, open_position_in};
            pins_r <= pinMeta_r;
        end
    end

    // 1 ms tick divider; all timers share it
    logic [15:0] tickCnt_r, tickCnt_nxt;
    logic msTick_r, msTick_nxt;
    always_comb begin
        msTick_nxt = (tickCnt_r == 16'(TICK_CYCLES - 1));
        tickCnt_nxt = msTick_nxt ? 16'h0000 : tickCnt_r + 16'h0001;
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tickCnt_r <= 16'h0000;
            msTick_r <= 1'b0;
        end else begin
            tickCnt_r <= tickCnt_nxt;
            msTick_r <= msTick_nxt;
        end
    end

    // Register file and APB slave state
    dsc_cfg_t cfg_r, cfg_nxt;
    logic [15:0] pulseMs_r, pulseMs_nxt, maxOpMs_r, maxOpMs_nxt;
    logic [15:0] maxIntMs_r, maxIntMs_nxt, sboMs_r, sboMs_nxt;
    logic [31:0] prdata_nxt;
    logic pready_nxt, pslverr_nxt;
    logic apbWr; // Write takes effect in the access cycle
    logic [31:0] statWord; // Live status for readback
    logic [31:0] opCount_r; // Operation counter, driven below
    logic errInv_r, errRej_r;
    always_comb begin
        cfg_nxt = cfg_r;
        pulseMs_nxt = pulseMs_r;
        maxOpMs_nxt = maxOpMs_r;
        maxIntMs_nxt = maxIntMs_r;
        sboMs_nxt = sboMs_r;
        apbWr = psel && penable && pready && pwrite;
        // Answer always one cycle after setup: zero wait states
        pready_nxt = psel && !penable;
        pslverr_nxt = pready_nxt && (paddr[7:5] != 3'h0 || paddr[1:0] != 2'h0);
        prdata_nxt = 32'h0000_0000;
        if (pready_nxt && !pwrite) begin
            unique case (paddr)
                ADDR_CFG: prdata_nxt = {26'h0, cfg_r};
                ADDR_PULSE: prdata_nxt = {16'h0000, pulseMs_r};
                ADDR_MAXOP: prdata_nxt = {16'h0000, maxOpMs_r};
                ADDR_MAXINT: prdata_nxt = {16'h0000, maxIntMs_r};
                ADDR_SBO: prdata_nxt = {16'h0000, sboMs_r};
                ADDR_STAT: prdata_nxt = statWord;
                ADDR_OPCNT: prdata_nxt = opCount_r;
                default: prdata_nxt = 32'h0000_0000; // CMD and unmapped read zero
            endcase
        end
        if (apbWr && !pslverr) begin
            unique case (paddr)
                ADDR_CFG: begin
                    cfg_nxt = dsc_cfg_t'(pwdata[5:0]);
                    // Code 3 is not a model; fall back to the safe default
                    if (pwdata[1:0] == 2'h3) begin
                        cfg_nxt.model = MODEL_DIRECT_NORMAL;
                    end
                    if (pwdata[4:2] > 3'h4) begin
                        cfg_nxt.swType = cfg_r.swType;
                    end
                end
                ADDR_PULSE: pulseMs_nxt = clampMs(pwdata[15:0], PULSE_MIN_MS,
                                                  SETTING_MAX_MS);
                ADDR_MAXOP: maxOpMs_nxt = clampMs(pwdata[15:0], MAXOP_MIN_MS,
                                                  SETTING_MAX_MS);
                ADDR_MAXINT: maxIntMs_nxt = clampMs(pwdata[15:0], MAXINT_MIN_MS,
                                                    SETTING_MAX_MS);
                ADDR_SBO: sboMs_nxt = clampMs(pwdata[15:0], SBO_MIN_MS, SBO_MAX_MS);
                default: begin
                end
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg_r <= CFG_RST;
            pulseMs_r <= PULSE_DEF_MS;
            maxOpMs_r <= MAXOP_DEF_MS;
            maxIntMs_r <= MAXINT_DEF_MS;
            sboMs_r <= SBO_DEF_MS;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            pulseMs_r <= pulseMs_nxt;
            maxOpMs_r <= maxOpMs_nxt;
            maxIntMs_r <= maxIntMs_nxt;
            sboMs_r <= sboMs_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

    // Position filtering, events, operation pulse and counter
    logic [1:0] posRaw; // Contact pair as a status code
    logic [15:0] intMs_r, intMs_nxt, operMs_r, operMs_nxt;
    logic [1:0] posCode_nxt;
    logic statusEvt_nxt, operActive_nxt, posChanged;
    logic [31:0] opCount_nxt;
    always_comb begin
        posRaw = {pins_r.posClosed, pins_r.posOpen};
        posCode_nxt = position_status_code;
        intMs_nxt = 16'h0000;
        if (posRaw == POS_OPEN || posRaw == POS_CLOSED) begin
            posCode_nxt = posRaw; // Clean positions show at once
        end else begin
            // Travel or contact fault stays hidden until the timer runs out
            intMs_nxt = msStep(intMs_r, msTick_r);
            if (intMs_r >= maxIntMs_r) begin
                posCode_nxt = posRaw;
            end
        end
        posChanged = (posCode_nxt != position_status_code);
        statusEvt_nxt = posChanged;
        operActive_nxt = operation_pulse;
        operMs_nxt = msStep(operMs_r, msTick_r);
        opCount_nxt = opCount_r;
        if (apbWr && paddr == ADDR_OPCNT) begin
            opCount_nxt = 32'h0000_0000;
        end
        if (operation_pulse && operMs_r >= OPER_PULSE_MS) begin
            operActive_nxt = 1'b0;
        end
        if (posChanged && (posCode_nxt == POS_OPEN || posCode_nxt == POS_CLOSED)) begin
            operActive_nxt = 1'b1;
            operMs_nxt = 16'h0000;
            // Count only a rising pulse; a restart while active is the same one
            if (!operation_pulse) begin
                opCount_nxt = opCount_nxt + 32'h0000_0001;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            intMs_r <= 16'h0000;
            operMs_r <= 16'h0000;
            position_status_code <= POS_INTERMEDIATE;
            status_event <= 1'b0;
            operation_pulse <= 1'b0;
            opCount_r <= 32'h0000_0000;
        end else begin
            intMs_r <= intMs_nxt;
            operMs_r <= operMs_nxt;
            position_status_code <= posCode_nxt;
            status_event <= statusEvt_nxt;
            operation_pulse <= operActive_nxt;
            opCount_r <= opCount_nxt;
        end
    end

    // Command sequencer with permit checks and supervision
    dsc_state_t state_r, state_nxt;
    dsc_cmd_t cmd;
    logic dirClose_r, dirClose_nxt, supActive_r, supActive_nxt;
    logic [15:0] cmdMs_r, cmdMs_nxt, supMs_r, supMs_nxt;
    logic cmdWr, srcOk, dirOk, checksOk, isSbo, isEnh, success, reject;
    logic errInv_nxt, errRej_nxt, openOut_nxt, closeOut_nxt;
    always_comb begin
        cmd = dsc_cmd_t'(pwdata[3:0]);
        cmdWr = apbWr && paddr == ADDR_CMD;
        srcOk = cmd.remote ? pins_r.remoteOk : pins_r.localOk;
        // Skip request honoured only when forced checking is off
        dirOk = (cmd.skipCheck && !cfg_r.forcedCheck) ||
                (cmd.close ? pins_r.closeOk : pins_r.openOk);
        checksOk = srcOk && dirOk && !pins_r.blocked;
        isSbo = (cfg_r.model == MODEL_SBO_ENH);
        isEnh = isSbo || (cfg_r.model == MODEL_DIRECT_ENH);
        success = (posRaw == (dirClose_r ? POS_CLOSED : POS_OPEN));
        state_nxt = state_r;
        dirClose_nxt = dirClose_r;
        cmdMs_nxt = msStep(cmdMs_r, msTick_r);
        supActive_nxt = supActive_r;
        supMs_nxt = msStep(supMs_r, msTick_r);
        reject = 1'b0;
        // Software clears sticky errors with ones; a new error set below wins
        errInv_nxt = errInv_r && !(apbWr && paddr == ADDR_STAT && pwdata[7]);
        errRej_nxt = errRej_r && !(apbWr && paddr == ADDR_STAT && pwdata[8]);
        unique case (state_r)
            ST_IDLE: begin
                if (cmdWr) begin
                    // A pending supervision still counts as executing
                    if (!checksOk || supActive_r || cmd.select != isSbo) begin
                        reject = 1'b1;
                    end else begin
                        state_nxt = isSbo ? ST_SELECTED : ST_PULSE;
                        dirClose_nxt = cmd.close;
                        cmdMs_nxt = 16'h0000;
                    end
                end
            end
            ST_SELECTED: begin
                if (cmdMs_r >= sboMs_r) begin
                    state_nxt = ST_IDLE;
                end else if (cmdWr) begin
                    // Operate must match the selected direction; else cancel
                    if (checksOk && !cmd.select && cmd.close == dirClose_r) begin
                        state_nxt = ST_PULSE;
                        cmdMs_nxt = 16'h0000;
                    end else begin
                        reject = 1'b1;
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_PULSE: begin
                reject = cmdWr;
                if (pins_r.blocked || cmdMs_r >= pulseMs_r ||
                    (success && cmdMs_r >= EARLY_END_MIN_MS)) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (state_r != ST_PULSE && state_nxt == ST_PULSE && isEnh) begin
            supActive_nxt = 1'b1;
            supMs_nxt = 16'h0000;
        end else if (supActive_r && success) begin
            supActive_nxt = 1'b0;
        end else if (supActive_r && supMs_r >= maxOpMs_r) begin
            supActive_nxt = 1'b0;
            errInv_nxt = 1'b1;
        end
        if (reject) begin
            errRej_nxt = 1'b1;
        end
        // Both pulses come from one state and one direction bit
        openOut_nxt = (state_nxt == ST_PULSE) && !dirClose_nxt;
        closeOut_nxt = (state_nxt == ST_PULSE) && dirClose_nxt;
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            dirClose_r <= 1'b0;
            cmdMs_r <= 16'h0000;
            supActive_r <= 1'b0;
            supMs_r <= 16'h0000;
            errInv_r <= 1'b0;
            errRej_r <= 1'b0;
            open_pulse_out <= 1'b0;
            close_pulse_out <= 1'b0;
            invalid_position_error <= 1'b0;
        end else begin
            state_r <= state_nxt;
            dirClose_r <= dirClose_nxt;
            cmdMs_r <= cmdMs_nxt;
            supActive_r <= supActive_nxt;
            supMs_r <= supMs_nxt;
            errInv_r <= errInv_nxt;
            errRej_r <= errRej_nxt;
            open_pulse_out <= openOut_nxt;
            close_pulse_out <= closeOut_nxt;
            invalid_position_error <= errInv_nxt;
        end
    end

    // Status word: filtered and raw position, sequencer and error flags
    assign statWord = {22'h0, operation_pulse, errRej_r, errInv_r, supActive_r,
                       state_r == ST_SELECTED, state_r != ST_IDLE, posRaw,
                       position_status_code};
endmodule

//--- tb/dsc_switchgear_model.sv
// Purpose: Switchgear contact model on the far side of the command pulses
// Assumes: Starts open; travel takes 40 cycles of an applied pulse
// Notes: Stuck leaves both contacts low, which looks like an intermediate state
module dsc_switchgear_model (
    input wire logic sys_clk,
    input wire logic open_pulse_out,
    input wire logic close_pulse_out,
    input wire logic stuck,
    output logic open_position_in,
    output logic closed_position_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0; // Cycles of the current pulse
    initial open_position_in = 1'b1;
    initial closed_position_in = 1'b0;
    // Old end contact drops first, then the new one makes, never both high
    always @(posedge sys_clk) begin
        cnt <= (open_pulse_out || close_pulse_out) ? cnt + 1 : 0;
        if (cnt == 20) begin
            open_position_in <= 1'b0;
            closed_position_in <= 1'b0;
        end
        if (cnt == 40 && !stuck) begin
            open_position_in <= open_pulse_out;
            closed_position_in <= close_pulse_out;
        end
    end
endmodule

//--- tb/dsc_switch_ctrl_checker.sv
// Purpose: Concurrent checks on the disconnector control ports
// Assumes: Pins pass two synchroniser flops inside the block
// Notes: Permit lookbacks span five cycles to cover synchroniser latency
module dsc_switch_ctrl_checker
    import dsc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic open_permit,
    input wire logic process_block,
    input wire logic open_position_in,
    input wire logic closed_position_in,
    input wire logic open_pulse_out,
    input wire logic close_pulse_out,
    input wire logic [1:0] position_status_code,
    input wire logic operation_pulse,
    input wire logic status_event,
    input wire logic invalid_position_error
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    int midCnt; // Cycles the raw contacts agree, no clean position
    int operHigh; // Cycles the operation pulse has been high
    // Helper counters for the long timers
    always_ff @(posedge sys_clk) begin
        midCnt <= (srst || open_position_in != closed_position_in) ? 0 : midCnt + 1;
        operHigh <= (srst || !operation_pulse) ? 0 : operHigh + 1;
    end
    a_pulse_excl: assert property (!(open_pulse_out && close_pulse_out))
        else $error("both command pulses high");
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_err_unmap: assert property (pready && psel && paddr[7:5] != 3'h0 |-> pslverr)
        else $error("unmapped access without error");
    a_block_nopulse: assert property ($rose(open_pulse_out || close_pulse_out) |->
        !($past(process_block, 1) && $past(process_block, 2) && $past(process_block, 3)
        && $past(process_block, 4) && $past(process_block, 5)))
        else $error("pulse while blocked");
    a_open_permit: assert property ($rose(open_pulse_out) |->
        $past(open_permit, 1) || $past(open_permit, 2) || $past(open_permit, 3)
        || $past(open_permit, 4) || $past(open_permit, 5))
        else $error("open pulse without open permit");
    a_event_change: assert property (status_event |->
        $past(position_status_code) != position_status_code
        || $past(position_status_code, 2) != $past(position_status_code))
        else $error("status event without change");
    a_event_pair: assert property ($changed(position_status_code) |-> status_event)
        else $error("status change without event");
    a_code_closed: assert property ($changed(position_status_code)
        && position_status_code == POS_CLOSED |->
        ($past(closed_position_in, 3) && !$past(open_position_in, 3))
        || ($past(closed_position_in, 4) && !$past(open_position_in, 4)))
        else $error("closed code without closed contact");
    a_oper_len: assert property ($fell(operation_pulse) |-> operHigh >= 149 * TICK_CYCLES)
        else $error("operation pulse too short");
    a_mid_filter: assert property ($changed(position_status_code)
        && (position_status_code == POS_INTERMEDIATE || position_status_code == POS_BAD)
        |-> midCnt >= 19 * TICK_CYCLES)
        else $error("intermediate shown too early");
    c_close: cover property ($rose(close_pulse_out));
    c_invalid: cover property ($rose(invalid_position_error));
    c_oper: cover property ($rose(operation_pulse));
endmodule
bind dsc_switch_ctrl dsc_switch_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES))
    i_dsc_switch_ctrl_checker (.*);

//--- tb/dsc_switch_ctrl_tb.sv
// Purpose: Directed APB test of the disconnector control block
// Assumes: 10 cycles per ms, so 100 ms is 1000 cycles
// Notes: Pins settle four cycles before a command to pass the synchronisers
module dsc_switch_ctrl_tb import dsc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 10; // Short tick for simulation
    logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
    logic pready, pslverr, erv, stuck = 0;
    logic local_control_permit = 1, remote_control_permit = 1, open_permit = 1;
    logic close_permit = 1, process_block = 0;
    logic open_position_in, closed_position_in, open_pulse_out, close_pulse_out;
    logic [1:0] position_status_code;
    logic operation_pulse, status_event, invalid_position_error;
    int error_cnt = 0, n_compared = 0, n;
    logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
    // Counter reads 1: the first clean position after reset counts as a change
    logic [31:0] rv [6] = '{32'h0000_0028, 32'h0000_03E8, 32'h0000_2710,
                            32'h0000_2710, 32'h0000_1388, 32'h0000_0001};
    // Pins local, remote, open, close, block; command word that must be refused
    logic [4:0] pins [6] = '{5'h0E, 5'h16, 5'h1A, 5'h1D, 5'h1C, 5'h1C};
    logic [31:0] cmds [6] = '{32'h0000_0000, 32'h0000_0002, 32'h0000_0000,
                              32'h0000_0000, 32'h0000_0001, 32'h0000_0009};
    always #10 sys_clk = ~sys_clk;
    dsc_switch_ctrl #(.TICK_CYCLES(TK)) i_dsc_switch_ctrl (.*);
    dsc_switchgear_model i_dsc_switchgear_model (.*);
    task close_out;
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            error_cnt++;
            close_out;
        end
        rdv = prdata;
        erv = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rdv);
    endtask
    // Length of the next command pulse in cycles, bounded both ways
    task plen;
        int k;
        k = 0;
        n = 0;
        while (!(open_pulse_out || close_pulse_out) && k < 10) begin
            @(posedge sys_clk);
            k++;
        end
        while ((open_pulse_out || close_pulse_out) && n < 20000) begin
            @(posedge sys_clk);
            n++;
        end
        // No pulse at all, or one that never ends, stops the run
        if (n == 0 || n >= 20000) begin
            error_cnt++;
            close_out;
        end
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        foreach (ra[i]) rd("reset value", ra[i], rv[i]);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped error", 1, erv);
        wr(ADDR_PULSE, 32'h0000_0032);
        rd("pulse clamp", ADDR_PULSE, 32'h0000_0064);
        wr(ADDR_MAXINT, 32'h0000_0014);
        wr(ADDR_MAXOP, 32'h0000_000A);
        wr(ADDR_SBO, 32'h0000_0000);
        rd("sbo clamp", ADDR_SBO, 32'h0000_03E8);
        chk("open code", POS_OPEN, position_status_code);
        // Direct close, with a second command while busy
        wr(ADDR_CMD, 32'h0000_0001);
        wr(ADDR_CMD, 32'h0000_0001);
        apb(1'b0, ADDR_STAT, 32'h0000_0000);
        chk("busy rejected", 32'h0000_0110, rdv & 32'h0000_0110);
        chk("close pulse", 1, close_pulse_out);
        plen;
        chk("pulse length", 1, n > 960 && n < 1010);
        chk("closed code", POS_CLOSED, position_status_code);
        chk("operation pulse", 1, operation_pulse);
        rd("op count", ADDR_OPCNT, 32'h0000_0001);
        wr(ADDR_STAT, 32'h0000_0180);
        repeat (2000) @(posedge sys_clk);
        wr(ADDR_OPCNT, 32'h0000_0000);
        rd("op count clear", ADDR_OPCNT, 32'h0000_0000);
        // Each refused case leaves no pulse and flags rejection
        foreach (pins[i]) begin
            {local_control_permit, remote_control_permit, open_permit, close_permit,
                process_block} <= pins[i];
            repeat (4) @(posedge sys_clk);
            wr(ADDR_CMD, cmds[i]);
            repeat (3) @(posedge sys_clk);
            chk("refused pulse", 0, open_pulse_out | close_pulse_out);
            apb(1'b0, ADDR_STAT, 32'h0000_0000);
            chk("refused flag", 1, rdv[8]);
            wr(ADDR_STAT, 32'h0000_0100);
        end
        close_permit <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wr(ADDR_CMD, 32'h0000_0002);
        plen;
        chk("remote open", POS_OPEN, position_status_code);
        repeat (2000) @(posedge sys_clk);
        // Forced check off lets skip bypass the close permit; long pulse ends at 1000 ms
        wr(ADDR_CFG, 32'h0000_0008);
        wr(ADDR_PULSE, 32'h0000_05DC);
        close_permit <= 1'b0;
        repeat (4) @(posedge sys_clk);
        wr(ADDR_CMD, 32'h0000_0009);
        plen;
        chk("skip accepted", 1, n > 9900 && n < 10100);
        close_permit <= 1'b1;
        rd("op count two", ADDR_OPCNT, 32'h0000_0002);
        // Direct enhanced with contacts that never arrive
        wr(ADDR_CFG, 32'h0000_0029);
        stuck <= 1'b1;
        wr(ADDR_CMD, 32'h0000_0000);
        plen;
        chk("invalid position", 1, invalid_position_error);
        chk("mid shown", POS_INTERMEDIATE, position_status_code);
        wr(ADDR_STAT, 32'h0000_0080);
        stuck <= 1'b0;
        // Select before operate: expiry, then prompt operate
        wr(ADDR_CFG, 32'h0000_002A);
        wr(ADDR_CMD, 32'h0000_0004);
        apb(1'b0, ADDR_STAT, 32'h0000_0000);
        chk("selected", 1, rdv[5]);
        repeat (10200) @(posedge sys_clk);
        wr(ADDR_CMD, 32'h0000_0000);
        repeat (3) @(posedge sys_clk);
        chk("expired select", 0, open_pulse_out);
        wr(ADDR_CMD, 32'h0000_0004);
        wr(ADDR_CMD, 32'h0000_0000);
        plen;
        chk("sbo operate", 1, n > 900);
        close_out;
    end
endmodule
